/* File: design/appset_top.sv */
// Purpose: Axis position preset unit; rewrites axis positions without motion
// Assumes: Request fields stable at the rising start edge
// Notes:   Motion in progress is never touched; only stored coordinates shift
`include "appset_defines.svh"
module appset_top (
    input  wire logic                      i_clk,
    input  wire logic                      i_nrst,
    input  wire logic                      i_start,
    input  appset_pkg::appset_req_t        i_req,
    input  wire logic [`APPSET_CHAN_W-1:0] i_mon_chan,
    output appset_pkg::appset_axis_t       o_mon_pos,
    output logic                           o_busy,
    output logic                           o_complete_flag,
    output logic                           o_error,
    output logic [`APPSET_FAULT_W-1:0]     o_fault_code
);
    // Execution steps
    typedef enum logic [1:0] {
        APPSET_IDLE,
        APPSET_READ,
        APPSET_WRITE,
        APPSET_HOLD
    } appset_state_t;

    appset_state_t            state_q;      // Sequencer state
    logic                     start_q;      // Previous start level
    appset_pkg::appset_req_t  req_q;        // Request caught at start edge
    appset_pkg::appset_axis_t rd_data;      // Store read data
    appset_pkg::appset_axis_t wr_data_d;    // New position pair
    logic                     wr_en;        // Store write strobe
    logic [`APPSET_CHAN_W-1:0] rd_addr;     // Store read address
    logic                     busy_q;       // Busy output register
    logic                     done_q;       // Complete output register
    logic                     err_q;        // Error output register
    logic [`APPSET_FAULT_W-1:0] fault_q;    // Fault code register
    appset_pkg::appset_axis_t mon_q;        // Monitor output register
    logic                     start_rise;   // Rising edge of start
    logic                     bad_chan;     // Channel outside the axis range

    // Target position: relative adds, absolute takes value
    function automatic appset_pkg::appset_pos_t target_pos(
        input appset_pkg::appset_pos_t ref_pos,
        input appset_pkg::appset_pos_t value,
        input logic                    rel
    );
        target_pos = rel ? appset_pkg::appset_pos_t'(ref_pos + value) : value;
    endfunction

    assign start_rise = i_start && !start_q;
    assign bad_chan   = i_req.chan > `APPSET_LAST_AXIS;

    // Read the preset axis while executing, else the monitor axis
    assign rd_addr = (state_q == APPSET_IDLE) ? i_mon_chan : req_q.chan;
    assign wr_en   = (state_q == APPSET_WRITE);

    // New pair, lag kept for either basis; captured read is the reference
    always_comb begin
        wr_data_d = rd_data;
        if (req_q.basis == `APPSET_BASIS_CMD) begin
            wr_data_d.cmd = target_pos(rd_data.cmd, req_q.value, req_q.offset_mode);
            wr_data_d.act = appset_pkg::appset_pos_t'(wr_data_d.cmd
                            - (rd_data.cmd - rd_data.act));
        end else begin
            wr_data_d.act = target_pos(rd_data.act, req_q.value, req_q.offset_mode);
            wr_data_d.cmd = appset_pkg::appset_pos_t'(wr_data_d.act
                            + (rd_data.cmd - rd_data.act));
        end
    end

    // Position store; only coordinates are written, no motion path exists
    appset_axis_mem u_mem (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_rd_addr (rd_addr),
        .o_rd_data (rd_data),
        .i_wr_en   (wr_en),
        .i_wr_addr (req_q.chan),
        .i_wr_data (wr_data_d)
    );

    // Start level history
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            start_q <= 1'h0;
        end else begin
            start_q <= i_start;
        end
    end

    // Request capture at the start edge only
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            req_q <= '0;
        end else if (state_q == APPSET_IDLE && start_rise) begin
            req_q <= i_req;
        end
    end

    // Sequencer: read reference, write once, hold flags until start low
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= APPSET_IDLE;
        end else begin
            case (state_q)
                APPSET_IDLE: begin
                    if (start_rise) begin
                        state_q <= bad_chan ? APPSET_HOLD : APPSET_READ;
                    end
                end
                APPSET_READ: begin
                    state_q <= APPSET_WRITE;
                end
                APPSET_WRITE: begin
                    state_q <= APPSET_HOLD;
                end
                default: begin
                    if (!i_start) begin
                        state_q <= APPSET_IDLE;
                    end
                end
            endcase
        end
    end

    // Busy while reading and writing
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_q <= 1'h0;
        end else if (state_q == APPSET_IDLE) begin
            busy_q <= start_rise && !bad_chan;
        end else if (state_q == APPSET_WRITE) begin
            busy_q <= 1'h0;
        end
    end

    // Complete once the write has landed; cleared when start drops
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            done_q <= 1'h0;
        end else if (state_q == APPSET_WRITE) begin
            done_q <= 1'h1;
        end else if (state_q == APPSET_HOLD && !i_start) begin
            done_q <= 1'h0;
        end
    end

    // Error on an axis outside the range; code held with the flag
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            err_q   <= 1'h0;
            fault_q <= `APPSET_FAULT_NONE;
        end else if (state_q == APPSET_IDLE && start_rise && bad_chan) begin
            err_q   <= 1'h1;
            fault_q <= `APPSET_FAULT_AXIS;
        end else if (state_q == APPSET_HOLD && !i_start) begin
            err_q   <= 1'h0;
            fault_q <= `APPSET_FAULT_NONE;
        end
    end

    // Monitor of stored positions, sampled while idle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mon_q <= '0;
        end else if (state_q == APPSET_IDLE) begin
            mon_q <= rd_data;
        end
    end

    assign o_busy          = busy_q;
    assign o_complete_flag = done_q;
    assign o_error         = err_q;
    assign o_fault_code    = fault_q;
    assign o_mon_pos       = mon_q;

    // Lag before and after the write must match
    sequence write_step_s;
        state_q == APPSET_WRITE;
    endsequence
    lag_kept_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        write_step_s |-> (wr_data_d.cmd - wr_data_d.act) == (rd_data.cmd - rd_data.act))
        else $error("lag changed by preset");
    busy_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(busy_q) |-> busy_q [*2] ##1 !busy_q)
        else $error("busy length wrong");
    done_after_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        write_step_s |=> done_q && !busy_q)
        else $error("complete not raised");
    done_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        done_q && i_start |=> done_q)
        else $error("complete dropped early");
    flag_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (done_q || err_q) && !i_start |=> !done_q && !err_q)
        else $error("flags not cleared");
    err_code_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        err_q |-> fault_q != `APPSET_FAULT_NONE)
        else $error("error without code");
    start_edge_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(busy_q) |-> $past(start_rise))
        else $error("busy without start edge");
    abs_value_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        write_step_s and (!req_q.offset_mode && req_q.basis == `APPSET_BASIS_CMD)
        |-> wr_data_d.cmd == req_q.value)
        else $error("absolute value wrong");
    act_basis_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        write_step_s and (!req_q.offset_mode && req_q.basis == `APPSET_BASIS_ACT)
        |-> wr_data_d.act == req_q.value)
        else $error("actual basis wrong");
endmodule

/* File: design/appset_defines.svh */
// Purpose: Named constants for the axis position preset unit
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only
`ifndef APPSET_DEFINES_SVH
`define APPSET_DEFINES_SVH
`define APPSET_POS_W       32
`define APPSET_CHAN_W      4
`define APPSET_NUM_AXES    16
`define APPSET_FAULT_W     16
`define APPSET_BASIS_CMD   1'h0
`define APPSET_BASIS_ACT   1'h1
`define APPSET_FAULT_NONE  16'h0000
`define APPSET_FAULT_AXIS  16'h0001
`define APPSET_POS_ZERO    32'h00000000
`define APPSET_LAST_AXIS   4'hB
`endif

/* File: design/appset_pkg.sv */
// Purpose: Types shared by the preset unit and its axis store
// Assumes: appset_defines.svh supplies the widths
// Notes:   Nothing here is imported; use appset_pkg::name
`include "appset_defines.svh"
package appset_pkg;
    typedef logic [`APPSET_POS_W-1:0] appset_pos_t;
    // One axis position pair
    typedef struct packed {
        logic [`APPSET_POS_W-1:0] cmd;
        logic [`APPSET_POS_W-1:0] act;
    } appset_axis_t;
    // Request fields sampled at the start edge
    typedef struct packed {
        logic [`APPSET_POS_W-1:0]  value;
        logic                      offset_mode;
        logic                      basis;
        logic [`APPSET_CHAN_W-1:0] chan;
    } appset_req_t;
endpackage

/* File: design/appset_axis_mem.sv */
// Purpose: Command and actual position store for all axes
// Assumes: One write port, one registered read port
// Notes:   The single write port serves the preset unit; no motion logic writes here
`include "appset_defines.svh"
module appset_axis_mem (
    input  wire logic                      i_clk,
    input  wire logic                      i_nrst,
    input  wire logic [`APPSET_CHAN_W-1:0] i_rd_addr,
    output appset_pkg::appset_axis_t       o_rd_data,
    input  wire logic                      i_wr_en,
    input  wire logic [`APPSET_CHAN_W-1:0] i_wr_addr,
    input  appset_pkg::appset_axis_t       i_wr_data
);
    // Storage array, no reset needed on contents beyond zero
    appset_pkg::appset_axis_t mem_q [`APPSET_NUM_AXES];
    appset_pkg::appset_axis_t rd_q;   // Registered read data

    // Write port
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < `APPSET_NUM_AXES; i++) begin
                mem_q[i] <= '0;
            end
        end else if (i_wr_en) begin
            mem_q[i_wr_addr] <= i_wr_data;
        end
    end

    // Read port; read data from a register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_q <= '0;
        end else begin
            rd_q <= mem_q[i_rd_addr];
        end
    end
    assign o_rd_data = rd_q;
endmodule

/* File: verif/appset_ctrl_model.sv */
// Purpose: Controlling program model that issues preset requests
// Assumes: Drives only just after rising edges of i_clk
// Notes:   Released request lines show inverted data, never stale values
module appset_ctrl_model (
    input  wire logic               i_clk,
    input  wire logic               i_busy,
    input  wire logic               i_done,
    input  wire logic               i_err,
    output logic                    o_start,
    output appset_pkg::appset_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle start level from time zero
    initial begin
        o_start = 1'h0;
        o_req   = '0;
    end

    // One preset: fields first, start rise one edge later, hold, drop
    task automatic run(input appset_pkg::appset_req_t r, input int hold,
                       output int busy_n, output logic fin, output logic err);
        busy_n = 0;
        fin    = 1'h0;
        err    = 1'h0;
        @(posedge i_clk);
        o_req <= r;
        @(posedge i_clk);
        o_start <= 1'h1;
        // Bounded wait so a silent unit cannot hang the run
        for (int n = 0; n < 8 && !(fin || err); n++) begin
            @(posedge i_clk);
            // Unknown busy counts as busy so it cannot pass a zero count
            busy_n += int'(i_busy !== 1'h0);
            fin = i_done;
            err = i_err;
        end
        // Start kept high: flags must stand meanwhile
        repeat (hold) @(posedge i_clk);
        fin = fin & i_done;
        err = err & i_err;
        o_start <= 1'h0;
        o_req   <= ~r;
    endtask
endmodule

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the axis position preset unit
// Assumes: Store is all zero after reset; no outside motion
// Notes:   Expected positions kept in a local shadow of every axis
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     i_clk;
    logic                     i_nrst;
    logic                     start;
    appset_pkg::appset_req_t  req;
    logic [3:0]               mon_chan;
    appset_pkg::appset_axis_t mon_pos;
    appset_pkg::appset_axis_t exp_pos [16]; // Shadow of the store
    logic                     busy;
    logic                     done;
    logic                     err;
    logic [15:0]              code;
    int                       fails      = 0;
    int                       n_compared = 0;
    int                       cycles     = 0;

    appset_top DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_start(start), .i_req(req),
        .i_mon_chan(mon_chan), .o_mon_pos(mon_pos), .o_busy(busy),
        .o_complete_flag(done), .o_error(err), .o_fault_code(code));
    appset_ctrl_model CTRL (.i_clk(i_clk), .i_busy(busy), .i_done(done),
        .i_err(err), .o_start(start), .o_req(req));

    // 250 MHz clock
    initial begin
        i_clk = 1'h0;
        forever #2 i_clk = ~i_clk;
    end

    // Hang guard, far above the hundred or so cycles needed
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            report_and_stop();
        end
    end

    // Flag, code and count results
    task automatic chk_flag(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t flag got %h exp %h", $time, got, exp);
        end
    endtask

    // Stored pair of one axis through the monitor port
    task automatic chk_pos(input logic [3:0] ch);
        @(posedge i_clk);
        mon_chan <= ch;
        repeat (3) @(posedge i_clk);
        n_compared++;
        if (mon_pos !== exp_pos[ch]) begin
            fails++;
            $display("[ERR] %0t axis %0d got %h exp %h", $time, ch, mon_pos, exp_pos[ch]);
        end
    endtask

    // One preset with expectations from the shadow
    task automatic preset(input logic [31:0] v, input logic rel, input logic bas,
                          input logic [3:0] ch, input int hold);
        int          bn;
        logic        f;
        logic        e;
        logic        bad;
        logic [31:0] nv;
        logic [31:0] lag;
        bad = (ch > 4'hB);
        lag = exp_pos[ch].cmd - exp_pos[ch].act;
        nv  = ((bas ? exp_pos[ch].act : exp_pos[ch].cmd) & {32{rel}}) + v;
        CTRL.run('{v, rel, bas, ch}, hold, bn, f, e);
        chk_flag(32'(bn), bad ? 32'h0 : 32'h2);
        chk_flag({31'h0, f}, {31'h0, !bad});
        chk_flag({15'h0, e, code}, bad ? 32'h00010001 : 32'h0);
        repeat (2) @(posedge i_clk);
        chk_flag({29'h0, busy, done, err}, 32'h0);
        if (!bad) begin
            exp_pos[ch].cmd = bas ? nv + lag : nv;
            exp_pos[ch].act = bas ? nv : nv - lag;
            chk_pos(ch);
        end
        $display("Test preset axis %0d done", ch);
    endtask

    // Counts, verdict and end of run
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        i_nrst   = 1'h0;
        mon_chan = 4'h0;
        foreach (exp_pos[k]) exp_pos[k] = '0;
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'h1;
        chk_flag({13'h0, busy, done, err, code}, 32'h0);
        chk_pos(4'h0);
        $display("Test reset done");
        preset(32'h00001770, 1'h0, 1'h0, 4'h3, 3);
        preset(32'hFFFFF830, 1'h1, 1'h0, 4'h3, 0);
        preset(32'h00002710, 1'h1, 1'h1, 4'h3, 1);
        preset(32'h80000000, 1'h0, 1'h1, 4'hB, 0);
        preset(32'h80000000, 1'h1, 1'h0, 4'hB, 0);
        chk_pos(4'h3);
        for (int c = 12; c < 16; c++) preset(32'h00000055, 1'h1, 1'h0, c[3:0], 1);
        chk_pos(4'hB);
        report_and_stop();
    end
endmodule
